// File: hw/perf_sel_pkg.sv
// Constants, register map and field layout of the event-selection block.
// Assumes one core clock and an AXI4-Lite register port with 8-bit addresses.
// How it works
// - Identity register reports debug-store presence at bit 21
// - Debug store emits branch and sampling records
// - Event code sits in bits 31:25
// - Sub-event mask sits in bits 24:9
// - Selector bits 15:13 must hold 05H for the counter to count
// - Branch event: code 06H, selector 05H, no sampling
// - Mask bits 0..3 pick four branch kinds
// - Each selection register feeds only its counters
// - User and kernel flags gate counting by level
// - Cascade: alternate overflow starts this counter
// - Enabled overflow raises the interrupt
// - Enabled counter counts forever, wrapping to zero
// - Enable bit 12 starts/stops, cleared by reset
// - Bit 31 is sticky overflow until cleared
package perf_sel_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CNT = 6;
  localparam int CNT_W_DEF = 40;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_ESEL0 = 8'h00;
  localparam logic [7:0] OFF_ESEL1 = 8'h04;
  localparam logic [7:0] OFF_CFG0 = 8'h10;
  localparam logic [7:0] OFF_CNT0 = 8'h30;
  localparam logic [7:0] OFF_ID = 8'h60;
  localparam logic [7:0] OFF_DS_CTRL = 8'h64;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h68;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h6c;

  // ************************************************************
  // Event-selection register fields
  // ************************************************************
  localparam int ES_CODE_LSB = 25;
  localparam int ES_CODE_MSB = 31;
  localparam int ES_MASK_LSB = 9;
  localparam int ES_MASK_MSB = 24;
  localparam int ES_KERNEL_BIT = 3;
  localparam int ES_USER_BIT = 2;
  localparam logic [31:0] ES_WMASK = 32'hfffffe0c;
  localparam logic [31:0] ES_RESET = 32'h00000000;

  // ************************************************************
  // Counter configuration register fields
  // ************************************************************
  localparam int CF_EN_BIT = 12;
  localparam int CF_SEL_LSB = 13;
  localparam int CF_SEL_MSB = 15;
  localparam int CF_IRQ_EN_BIT = 26;
  localparam int CF_CASC_BIT = 30;
  localparam int CF_OVF_BIT = 31;
  localparam logic [31:0] CF_WMASK = 32'hc400f000;
  localparam logic [31:0] CF_RESET = 32'h00000000;

  // ************************************************************
  // Retired-branch event and counter topology
  // ************************************************************
  localparam logic [6:0] BRANCH_CODE = 7'h06;
  localparam logic [2:0] BRANCH_SEL = 3'h5;
  localparam int BRANCH_KINDS = 4;
  // Bank of each counter, bit i = counter i (counters 12..17 as 0..5)
  localparam logic [NUM_CNT-1:0] BANK_OF = 6'b101100;
  // Cascade source of each counter, three bits per counter
  localparam logic [3*NUM_CNT-1:0] CASC_SRC = {3'h3, 3'h2, 3'h1, 3'h0, 3'h3, 3'h2};

  // ************************************************************
  // Identity and debug store
  // ************************************************************
  localparam int ID_DS_BIT = 21;
  localparam int DS_BRANCH_BIT = 0;
  localparam int DS_SAMPLE_BIT = 1;

  // ************************************************************
  // AXI responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : perf_sel_pkg

// File: hw/event_qualifier.sv
// Qualifies one incoming event against one event-selection register.
// Assumes event inputs are synchronous to the core clock.
`timescale 1ns/1ns
module event_qualifier (
  // Selection register
  input wire logic [31:0] esel,
  // Event stream
  input wire logic evt_valid,
  input wire logic [6:0] evt_class,
  input wire logic [15:0] evt_sub,
  input wire logic priv_user,
  // Result
  output logic hit
);
  import perf_sel_pkg::*;

  logic code_ok;
  logic sub_ok;
  logic level_ok;

  always_comb begin
    code_ok = (evt_class == esel[ES_CODE_MSB:ES_CODE_LSB]);
    sub_ok = |(evt_sub & esel[ES_MASK_MSB:ES_MASK_LSB]);
    level_ok = priv_user ? esel[ES_USER_BIT] : esel[ES_KERNEL_BIT];
    hit = evt_valid & code_ok & sub_ok & level_ok;
  end

endmodule : event_qualifier

// File: hw/perf_counter.sv
// One counter with its configuration register.
// Assumes the parent has already merged byte strobes into the write data.
`timescale 1ns/1ns
module perf_counter #(
  parameter int CNT_W = perf_sel_pkg::CNT_W_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Software writes
  input wire logic cfg_we,
  input wire logic cnt_lo_we,
  input wire logic cnt_hi_we,
  input wire logic [31:0] wdata,
  // Event and cascade
  input wire logic bank_hit,
  input wire logic alt_ovf,
  // State
  output logic [31:0] cfg_out,
  output logic [CNT_W-1:0] count_out,
  output logic wrap
);
  import perf_sel_pkg::*;

  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic running;
  logic advance;

  always_comb begin
    running = cfg_reg[CF_EN_BIT] | (cfg_reg[CF_CASC_BIT] & alt_ovf);
    advance = running & bank_hit & (cfg_reg[CF_SEL_MSB:CF_SEL_LSB] == BRANCH_SEL);
    wrap = advance & (&count_reg) & ~(cnt_lo_we | cnt_hi_we);
    count_next = count_reg;
    if (cnt_lo_we) begin
      count_next = {count_reg[CNT_W-1:32], wdata};
    end else if (cnt_hi_we) begin
      count_next = {wdata[CNT_W-33:0], count_reg[31:0]};
    end else if (advance) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    cfg_next = cfg_reg;
    if (cfg_we) begin
      cfg_next = wdata & CF_WMASK;
    end
    // A wrap in the clearing cycle is not lost
    if (wrap) begin
      cfg_next[CF_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CF_RESET;
      count_reg <= '0;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      count_reg <= count_next;
    end
  end

  assign cfg_out = cfg_reg;
  assign count_out = count_reg;

endmodule : perf_counter

// File: hw/perf_counter_event_select.sv
// Top of the event-selection block: AXI4-Lite slave, selection registers,
// six counters, interrupt status and debug-store record strobes.
// Assumes event inputs are synchronous to aclk and one bus master.
`timescale 1ns/1ns
module perf_counter_event_select #(
  parameter int CNT_W = perf_sel_pkg::CNT_W_DEF,
  parameter logic DS_PRESENT = 1'b1
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Event stream from the core
  input wire logic evt_valid,
  input wire logic [6:0] evt_class,
  input wire logic [15:0] evt_sub,
  input wire logic priv_user,
  // Interrupt
  output logic counter_overflow_interrupt,
  // Debug store record strobes
  output logic branch_rec_valid,
  output logic [perf_sel_pkg::BRANCH_KINDS-1:0] branch_rec_kind,
  output logic precise_sampling_record,
  output logic [2:0] sample_rec_counter
);
  import perf_sel_pkg::*;

  // ************************************************************
  // Bus slave state
  // ************************************************************
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_write;
  logic do_read;
  logic [31:0] bmask;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;

  // ************************************************************
  // Block registers
  // ************************************************************
  logic [31:0] esel_reg [2];
  logic [31:0] esel_next [2];
  logic [NUM_CNT-1:0] irq_stat_reg, irq_stat_next;
  logic [NUM_CNT-1:0] irq_mask_reg, irq_mask_next;
  logic [1:0] ds_ctrl_reg, ds_ctrl_next;
  logic irq_reg, irq_next;
  logic br_rec_reg, br_rec_next;
  logic [BRANCH_KINDS-1:0] br_kind_reg, br_kind_next;
  logic smp_rec_reg, smp_rec_next;
  logic [2:0] smp_cnt_reg, smp_cnt_next;

  logic [1:0] bank_hit;
  logic [31:0] cfg_val [NUM_CNT];
  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] wrap;
  logic [NUM_CNT-1:0] cfg_we;
  logic [NUM_CNT-1:0] lo_we;
  logic [NUM_CNT-1:0] hi_we;
  logic [31:0] cnt_wdata [NUM_CNT];
  logic [31:0] cfg_wdata [NUM_CNT];

  // ************************************************************
  // Event qualification, one per selection bank
  // ************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      event_qualifier u_qual (
        .esel(esel_reg[gb]),
        .evt_valid(evt_valid),
        .evt_class(evt_class),
        .evt_sub(evt_sub),
        .priv_user(priv_user),
        .hit(bank_hit[gb])
      );
    end
  endgenerate

  // ************************************************************
  // Counters
  // ************************************************************
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CNT; gc++) begin : g_cnt
      logic [31:0] lo_merged;
      logic [31:0] hi_merged;
      logic [31:0] hi_cur;
      assign hi_cur = {{(64-CNT_W){1'b0}}, cnt_val[gc][CNT_W-1:32]};
      assign lo_merged = (cnt_val[gc][31:0] & ~bmask) | (w_data_reg & bmask);
      assign hi_merged = (hi_cur & ~bmask) | (w_data_reg & bmask);
      assign cfg_wdata[gc] = (cfg_val[gc] & ~bmask) | (w_data_reg & bmask);
      assign cnt_wdata[gc] = hi_we[gc] ? hi_merged : (lo_we[gc] ? lo_merged : cfg_wdata[gc]);
      assign cfg_we[gc] = do_write && aw_addr_reg == OFF_CFG0 + 8'(4 * gc);
      assign lo_we[gc] = do_write && aw_addr_reg == OFF_CNT0 + 8'(8 * gc);
      assign hi_we[gc] = do_write && aw_addr_reg == OFF_CNT0 + 8'(8 * gc + 4);

      perf_counter #(
        .CNT_W(CNT_W)
      ) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .cfg_we(cfg_we[gc]),
        .cnt_lo_we(lo_we[gc]),
        .cnt_hi_we(hi_we[gc]),
        .wdata(cnt_wdata[gc]),
        .bank_hit(bank_hit[BANK_OF[gc]]),
        .alt_ovf(cfg_val[CASC_SRC[3*gc +: 3]][CF_OVF_BIT]),
        .cfg_out(cfg_val[gc]),
        .count_out(cnt_val[gc]),
        .wrap(wrap[gc])
      );
    end
  endgenerate

  // ************************************************************
  // Bus slave next state
  // ************************************************************
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    bmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    do_read = arvalid & ~rvalid_reg;
    // Address and data are taken in either order
    if (awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = {awaddr[7:2], 2'b00};
    end
    if (wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    wr_hit = (aw_addr_reg == OFF_ESEL0) || (aw_addr_reg == OFF_ESEL1) || (aw_addr_reg == OFF_DS_CTRL) ||
             (aw_addr_reg == OFF_IRQ_STAT) || (aw_addr_reg == OFF_IRQ_MASK) || (|cfg_we) || (|lo_we) ||
             (|hi_we) || (aw_addr_reg == OFF_ID);
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case ({araddr[7:2], 2'b00})
      OFF_ESEL0: rd_val = esel_reg[0];
      OFF_ESEL1: rd_val = esel_reg[1];
      OFF_ID: rd_val[ID_DS_BIT] = DS_PRESENT;
      OFF_DS_CTRL: rd_val[1:0] = ds_ctrl_reg;
      OFF_IRQ_STAT: rd_val[NUM_CNT-1:0] = irq_stat_reg;
      OFF_IRQ_MASK: rd_val[NUM_CNT-1:0] = irq_mask_reg;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_CNT; i++) begin
          if ({araddr[7:2], 2'b00} == OFF_CFG0 + 8'(4 * i)) begin
            rd_val = cfg_val[i];
            rd_hit = 1'b1;
          end
          if ({araddr[7:2], 2'b00} == OFF_CNT0 + 8'(8 * i)) begin
            rd_val = cnt_val[i][31:0];
            rd_hit = 1'b1;
          end
          if ({araddr[7:2], 2'b00} == OFF_CNT0 + 8'(8 * i + 4)) begin
            rd_val = {{(64-CNT_W){1'b0}}, cnt_val[i][CNT_W-1:32]};
            rd_hit = 1'b1;
          end
        end
      end
    endcase
    if (do_read) begin
      rvalid_next = 1'b1;
      rdata_next = rd_hit ? rd_val : 32'h00000000;
      rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ************************************************************
  // Block register next state
  // ************************************************************
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      esel_next[b] = esel_reg[b];
    end
    irq_mask_next = irq_mask_reg;
    ds_ctrl_next = ds_ctrl_reg;
    irq_stat_next = irq_stat_reg;
    if (do_write) begin
      // Reserved bits outside ES_WMASK are stored as zero, whatever software writes
      if (aw_addr_reg == OFF_ESEL0) begin
        esel_next[0] = ((esel_reg[0] & ~bmask) | (w_data_reg & bmask)) & ES_WMASK;
      end
      if (aw_addr_reg == OFF_ESEL1) begin
        esel_next[1] = ((esel_reg[1] & ~bmask) | (w_data_reg & bmask)) & ES_WMASK;
      end
      if (aw_addr_reg == OFF_IRQ_MASK) begin
        irq_mask_next = (irq_mask_reg & ~bmask[NUM_CNT-1:0]) | (w_data_reg[NUM_CNT-1:0] & bmask[NUM_CNT-1:0]);
      end
      if (aw_addr_reg == OFF_DS_CTRL) begin
        ds_ctrl_next = (ds_ctrl_reg & ~bmask[1:0]) | (w_data_reg[1:0] & bmask[1:0]);
      end
      if (aw_addr_reg == OFF_IRQ_STAT) begin
        irq_stat_next = irq_stat_reg & ~(w_data_reg[NUM_CNT-1:0] & bmask[NUM_CNT-1:0]);
      end
    end
    // New overflow wins over a clear in the same cycle
    for (int i = 0; i < NUM_CNT; i++) begin
      if (wrap[i] && cfg_val[i][CF_IRQ_EN_BIT]) begin
        irq_stat_next[i] = 1'b1;
      end
    end
    irq_next = |(irq_stat_next & irq_mask_next);

    // Branch records only for the retired-branch class
    br_rec_next = DS_PRESENT & ds_ctrl_reg[DS_BRANCH_BIT] & evt_valid &
                  (evt_class == BRANCH_CODE) & (|evt_sub[BRANCH_KINDS-1:0]);
    br_kind_next = br_rec_next ? evt_sub[BRANCH_KINDS-1:0] : br_kind_reg;
    // Sampling records never for the branch event, which lacks support
    smp_rec_next = 1'b0;
    smp_cnt_next = smp_cnt_reg;
    for (int i = NUM_CNT - 1; i >= 0; i--) begin
      if (wrap[i] && DS_PRESENT && ds_ctrl_reg[DS_SAMPLE_BIT] &&
          esel_reg[BANK_OF[i]][ES_CODE_MSB:ES_CODE_LSB] != BRANCH_CODE) begin
        smp_rec_next = 1'b1;
        smp_cnt_next = 3'(i);
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
      esel_reg[0] <= ES_RESET;
      esel_reg[1] <= ES_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      ds_ctrl_reg <= 2'h0;
      irq_reg <= 1'b0;
      br_rec_reg <= 1'b0;
      br_kind_reg <= '0;
      smp_rec_reg <= 1'b0;
      smp_cnt_reg <= 3'h0;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      esel_reg[0] <= esel_next[0];
      esel_reg[1] <= esel_next[1];
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      ds_ctrl_reg <= ds_ctrl_next;
      irq_reg <= irq_next;
      br_rec_reg <= br_rec_next;
      br_kind_reg <= br_kind_next;
      smp_rec_reg <= smp_rec_next;
      smp_cnt_reg <= smp_cnt_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign awready = ~aw_held_reg;
  assign wready = ~w_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = ~rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign counter_overflow_interrupt = irq_reg;
  assign branch_rec_valid = br_rec_reg;
  assign branch_rec_kind = br_kind_reg;
  assign precise_sampling_record = smp_rec_reg;
  assign sample_rec_counter = smp_cnt_reg;

endmodule : perf_counter_event_select

// File: test/perf_counter_event_select_props.sv
// Checker of the event-selection block: bus timing, identity flag, interrupt causes.
// Assumes one clock domain; bound to the top module, sees its ports only.
`timescale 1ns/1ns
module perf_counter_event_select_props #(
  parameter int CNT_W = perf_sel_pkg::CNT_W_DEF,
  parameter logic DS_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Events and outputs
  input wire logic evt_valid,
  input wire logic [6:0] evt_class,
  input wire logic counter_overflow_interrupt,
  input wire logic branch_rec_valid
);
  import perf_sel_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // Sequences
  // ****
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  // Record may follow its branch by one or two edges
  sequence s_branch_1;
    $past(evt_valid) && $past(evt_class) == BRANCH_CODE;
  endsequence
  sequence s_branch_2;
    $past(evt_valid, 2) && $past(evt_class, 2) == BRANCH_CODE;
  endsequence
  // ****
  // Properties
  // ****
  AST_WR_RESP: assert property (s_wr_take |=> !bvalid ##1 bvalid)
    else $error("write response not on second edge");
  AST_RD_RESP: assert property (s_rd_take |=> rvalid)
    else $error("read data not on next edge");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  AST_ID_FLAG: assert property (arvalid && arready && araddr == OFF_ID |=>
    rdata[ID_DS_BIT] == DS_PRESENT && rresp == RESP_OKAY)
    else $error("identity flag wrong");
  AST_UNMAPPED_READ: assert property (arvalid && arready && araddr == 8'h70 |=>
    rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_IRQ_RISE: assert property ($rose(counter_overflow_interrupt) |->
    $past(evt_valid) || bvalid || $past(bvalid))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(counter_overflow_interrupt) |-> bvalid || $past(bvalid))
    else $error("interrupt fell without software");
  AST_BRANCH_REC: assert property (branch_rec_valid |-> s_branch_1 or s_branch_2)
    else $error("branch record without branch");
endmodule : perf_counter_event_select_props

bind perf_counter_event_select perf_counter_event_select_props #(.CNT_W(CNT_W), .DS_PRESENT(DS_PRESENT)) u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .evt_valid(evt_valid), .evt_class(evt_class),
  .counter_overflow_interrupt(counter_overflow_interrupt), .branch_rec_valid(branch_rec_valid)
);

// File: test/perf_counter_event_select_bench.sv
// Self-checking bench of the event-selection block: registers, counting, interrupt, cascade.
// Assumes the design package is compiled first and the checker is bound to the top.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module perf_counter_event_select_bench;
  import perf_sel_pkg::*;
  // ****
  // Stimulus state
  // ****
  localparam logic [31:0] SEL4 = 32'h4 << CF_SEL_LSB;
  localparam logic [31:0] SEL5 = 32'(BRANCH_SEL) << CF_SEL_LSB;
  localparam logic [31:0] EN = 32'h1 << CF_EN_BIT;
  localparam logic [31:0] IRQEN = 32'h1 << CF_IRQ_EN_BIT;
  localparam logic [31:0] CASC = 32'h1 << CF_CASC_BIT;
  // User level, both predicted kinds; kernel level, both mispredicted kinds
  localparam logic [31:0] ES_A = {BRANCH_CODE, 16'h0005, 5'h00, 1'b0, 1'b1, 2'h0};
  localparam logic [31:0] ES_B = {BRANCH_CODE, 16'h000a, 5'h00, 1'b1, 1'b0, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d, rdata;
  logic [3:0] wstrb = 4'hf, branch_rec_kind, kind = 4'h0;
  logic evt_valid = 1'b0, priv_user = 1'b0;
  logic [6:0] evt_class = 7'h00;
  logic [15:0] evt_sub = 16'h0000, rnd = 16'h22e8;
  logic awready, wready, bvalid, arready, rvalid, counter_overflow_interrupt, branch_rec_valid;
  logic precise_sampling_record;
  logic [1:0] bresp, rresp;
  logic [2:0] sample_rec_counter;
  int n_mismatch = 0, check_count = 0, n0, n2, n;

  perf_counter_event_select u_perf_counter_event_select (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .evt_valid(evt_valid), .evt_class(evt_class),
    .evt_sub(evt_sub), .priv_user(priv_user), .counter_overflow_interrupt(counter_overflow_interrupt),
    .branch_rec_valid(branch_rec_valid), .branch_rec_kind(branch_rec_kind),
    .precise_sampling_record(precise_sampling_record), .sample_rec_counter(sample_rec_counter)
  );

  always #10 aclk = ~aclk;

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic qual(input logic [31:0] es, input logic v, input logic [6:0] c,
                                input logic [15:0] s, input logic u);
    return v && c == es[ES_CODE_MSB:ES_CODE_LSB] && (s & es[ES_MASK_MSB:ES_MASK_LSB]) != 16'h0
      && (u ? es[ES_USER_BIT] : es[ES_KERNEL_BIT]);
  endfunction : qual

  task automatic results;
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task automatic step;
    @(posedge aclk);
    rnd = lfsr_next(rnd);
  endtask : step

  // Response ready rises after a random delay
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic done = 1'b0;
    step;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= rnd[0];
    while (!done) begin
      step;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        bready <= 1'b0;
        `CHK(bresp, er)
      end else if (!bready) bready <= rnd[1];
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    logic done = 1'b0;
    step;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= rnd[0];
    while (!done) begin
      step;
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        v = rdata;
        rready <= 1'b0;
        `CHK(rresp, er)
      end else if (!rready) rready <= rnd[1];
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v, RESP_OKAY);
    `CHK(v, e)
  endtask : rc

  task automatic evts(input int k, input logic [31:0] es, output int cnt);
    logic [6:0] c;
    logic [15:0] s;
    cnt = 0;
    repeat (k) begin
      step;
      c = rnd[1] ? BRANCH_CODE : 7'h07;
      s = {rnd[7:0], rnd[15:8]};
      evt_valid <= rnd[0];
      evt_class <= c;
      evt_sub <= s;
      priv_user <= rnd[2];
      cnt += int'(qual(es, rnd[0], c, s, rnd[2]));
      if (rnd[0] && rnd[1] && s[3:0] != 4'h0) kind = s[3:0];
    end
    step;
    evt_valid <= 1'b0;
  endtask : evts

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NUM_CNT; i++) rc(OFF_CFG0 + 8'(4 * i), CF_RESET);
    rd(OFF_ID, d, RESP_OKAY);
    `CHK(d[ID_DS_BIT], 1'b1)
    rd(8'h70, d, RESP_SLVERR);
    wr(8'h70, 32'hffffffff, RESP_SLVERR);
    repeat (4) begin
      d = {rnd, lfsr_next(rnd)};
      wr(OFF_ESEL0, d, RESP_OKAY);
      rc(OFF_ESEL0, d & ES_WMASK);
      wr(OFF_CFG0 + 8'h04, d, RESP_OKAY);
      rc(OFF_CFG0 + 8'h04, d & CF_WMASK);
    end
    wr(OFF_DS_CTRL, 32'h3, RESP_OKAY);
    wr(OFF_ESEL0, ES_A, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(OFF_CNT0, 32'hffffffff, RESP_OKAY);
    wr(OFF_CNT0 + 8'h04, 32'hff, RESP_OKAY);
    wr(OFF_CFG0 + 8'h04, SEL4 | EN, RESP_OKAY);
    wr(OFF_CFG0 + 8'h08, SEL5 | EN, RESP_OKAY);
    wr(OFF_CFG0, SEL5 | EN | IRQEN, RESP_OKAY);
    evts(80, ES_A, n0);
    rc(OFF_CNT0, 32'hffffffff + 32'(n0));
    rc(OFF_CNT0 + 8'h04, n0 > 0 ? 32'h0 : 32'hff);
    `CHK(branch_rec_kind, kind)
    rc(OFF_CFG0, SEL5 | EN | IRQEN | {n0 > 0, 31'h0});
    rc(OFF_CNT0 + 8'h08, 32'h0);
    rc(OFF_CNT0 + 8'h10, 32'h0);
    `CHK(counter_overflow_interrupt, n0 > 0)
    wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    step;
    `CHK(counter_overflow_interrupt, 1'b0)
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    step;
    `CHK(counter_overflow_interrupt, n0 > 0)
    wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    step;
    `CHK(counter_overflow_interrupt, 1'b0)
    rc(OFF_IRQ_STAT, 32'h0);
    wr(OFF_CFG0, SEL5 | IRQEN | {n0 > 0, 31'h0}, RESP_OKAY);
    evts(40, ES_A, n);
    rc(OFF_CNT0, 32'hffffffff + 32'(n0));
    rc(OFF_CFG0, SEL5 | IRQEN | {n0 > 0, 31'h0});
    wr(OFF_ESEL1, ES_B, RESP_OKAY);
    wr(OFF_CNT0 + 8'h10, 32'h0, RESP_OKAY);
    wr(OFF_CFG0 + 8'h08, SEL5 | CASC, RESP_OKAY);
    evts(40, ES_B, n2);
    rc(OFF_CNT0 + 8'h10, n0 > 0 ? 32'(n2) : 32'h0);
    wr(OFF_CFG0, SEL5 | IRQEN, RESP_OKAY);
    evts(40, ES_B, n);
    rc(OFF_CNT0 + 8'h10, n0 > 0 ? 32'(n2) : 32'h0);
    results;
  end

  // Run takes a few hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    results;
  end
endmodule : perf_counter_event_select_bench
